// file: hw/wfd_pkg.sv
// Package of the wake frame detector: register map, field positions, reset values and carriers.
// Assumes a single 25 MHz clock shared by the receive byte stream and the register port.
`default_nettype none
package wfd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PULSE_NS = 320;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] ADDR_INT_STATUS_TWO = 16'h0013;
  localparam logic [15:0] ADDR_RX_FILTER_CONFIG = 16'h04A0;
  localparam logic [15:0] ADDR_RX_FILTER_STATUS = 16'h04A1;
  localparam logic [15:0] ADDR_STATION_0 = 16'h04A2;
  localparam logic [15:0] ADDR_PASSWORD_0 = 16'h04A5;
  localparam logic [15:0] ADDR_PATTERN_LEN = 16'h04A8;
  localparam logic [15:0] ADDR_PATTERN_BASE = 16'h04C0;
  localparam int unsigned PATTERN_WORDS = 32;
  localparam int unsigned PATTERN_BYTES = 64;
  localparam int unsigned SYNC_BYTES = 6;
  localparam int unsigned ADDR_COPIES = 16;
  localparam int unsigned ADDR_BYTES = 6;
  localparam logic [7:0] SYNC_VALUE = 8'hFF;
  localparam logic [47:0] BROADCAST = 48'hFFFF_FFFF_FFFF;
  // Configuration bits.
  localparam int unsigned CFG_MAGIC_EN = 0;
  localparam int unsigned CFG_PATTERN_EN = 1;
  localparam int unsigned CFG_PASS_EN = 2;
  localparam int unsigned CFG_BCAST_EN = 3;
  localparam int unsigned CFG_LEVEL_MODE = 4;
  localparam int unsigned CFG_GPIO_SEL = 5;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Status bits; only wake and reject exist in both status registers.
  localparam int unsigned ST_WAKE = 0;
  localparam int unsigned ST_REJECT = 1;
  localparam int unsigned ST_MAGIC = 2;
  localparam int unsigned ST_PATTERN = 3;
  localparam int unsigned ST_SPEED = 4;
  localparam int unsigned INT_MASK_POS = 8;
  typedef struct packed {
    logic vld;
    logic [7:0] data;
    logic sof;
    logic eof;
    logic crc_err;
  } wfd_rx_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wfd_bus_t;
  function automatic logic [7:0] wfd_byte_of(input logic [47:0] v, input logic [2:0] i);
    logic [5:0] sh;
    sh = 6'(8 * (5 - int'(i)));
    wfd_byte_of = 8'(v >> sh);
  endfunction
endpackage
`default_nettype wire

// file: hw/wfd_magic_seq.sv
// Sequence hunter for the synchronization stream, sixteen address copies and password.
// Assumes one byte per valid strobe on the same clock and a start strobe for each frame.
`default_nettype none
module wfd_magic_seq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic byte_vld,
  input wire logic [7:0] byte_data,
  input wire logic frame_start,
  input wire logic [47:0] station,
  input wire logic [47:0] password,
  input wire logic pass_en,
  output logic found
);
  typedef enum logic [1:0] {WFD_SYNC, WFD_ADDR, WFD_PASS, WFD_DONE} wfd_seq_t;
  wfd_seq_t state_ff, nxt_state;
  logic [2:0] sync_ff, nxt_sync;
  logic [2:0] pos_ff, nxt_pos;
  logic [3:0] copy_ff, nxt_copy;
  wire logic is_sync = byte_data == wfd_pkg::SYNC_VALUE;
  wire logic addr_hit = byte_data == wfd_pkg::wfd_byte_of(station, pos_ff);
  wire logic pass_hit = byte_data == wfd_pkg::wfd_byte_of(password, pos_ff);
  wire logic last_pos = pos_ff == 3'(wfd_pkg::ADDR_BYTES - 1);
  wire logic last_copy = copy_ff == 4'(wfd_pkg::ADDR_COPIES - 1);
  wire logic sync_full = sync_ff == 3'(wfd_pkg::SYNC_BYTES);
  wire logic [2:0] restart = is_sync ? 3'h1 : 3'h0;
  always_comb begin
    nxt_state = state_ff;
    nxt_sync = sync_ff;
    nxt_pos = pos_ff;
    nxt_copy = copy_ff;
    if (frame_start) begin
      nxt_state = WFD_SYNC;
      nxt_sync = 3'h0;
      nxt_pos = 3'h0;
    end else if (byte_vld) begin
      case (state_ff)
        WFD_SYNC: begin
          if (sync_full && addr_hit) begin
            nxt_state = WFD_ADDR;
            nxt_pos = 3'h1;
            nxt_copy = 4'h0;
          end else if (is_sync) begin
            nxt_sync = sync_full ? sync_ff : sync_ff + 3'h1;
          end else begin
            nxt_sync = 3'h0;
          end
        end
        WFD_ADDR: begin
          if (!addr_hit) begin
            nxt_state = WFD_SYNC;
            nxt_sync = restart;
            nxt_pos = 3'h0;
          end else if (last_pos) begin
            nxt_pos = 3'h0;
            nxt_copy = copy_ff + 4'h1;
            if (last_copy) begin
              nxt_state = pass_en ? WFD_PASS : WFD_DONE;
            end
          end else begin
            nxt_pos = pos_ff + 3'h1;
          end
        end
        WFD_PASS: begin
          if (!pass_hit) begin
            nxt_state = WFD_SYNC;
            nxt_sync = restart;
            nxt_pos = 3'h0;
          end else if (last_pos) begin
            nxt_state = WFD_DONE;
          end else begin
            nxt_pos = pos_ff + 3'h1;
          end
        end
        WFD_DONE: nxt_state = WFD_DONE;
        default: nxt_state = WFD_SYNC;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= WFD_SYNC;
      sync_ff <= 3'h0;
      pos_ff <= 3'h0;
      copy_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      sync_ff <= nxt_sync;
      pos_ff <= nxt_pos;
      copy_ff <= nxt_copy;
    end
  end
  assign found = state_ff == WFD_DONE;
  sync_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == WFD_SYNC && nxt_state == WFD_ADDR) |-> sync_ff == 3'h6)
    else $error("Address run entered without six sync bytes.");
  break_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == WFD_ADDR && byte_vld && !frame_start && !addr_hit)
    |=> state_ff == WFD_SYNC && sync_ff == $past(restart) && pos_ff == 3'h0)
    else $error("Broken address run did not restart the search.");
endmodule
`default_nettype wire

// file: hw/wfd_detector.sv
// Wake frame detector top: register port, frame qualification, custom pattern, events.
// Assumes the receive byte stream and the register port share sys_clk; no synchronizers.
`default_nettype none
module wfd_detector (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire wfd_pkg::wfd_rx_t rx,
  input wire logic [1:0] rx_speed,
  input wire wfd_pkg::wfd_bus_t bus,
  output logic [15:0] rdata,
  output logic irq,
  output logic [3:0] gpio_event
);
  logic [15:0] cfg_ff;
  logic [15:0] fstat_ff, nxt_fstat;
  logic [1:0] istat_ff, nxt_istat;
  logic [1:0] imask_ff;
  logic [47:0] station_ff;
  logic [47:0] password_ff;
  logic [6:0] pat_len_ff;
  logic [15:0] pattern_mem [wfd_pkg::PATTERN_WORDS];
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] count_ff;
  logic dest_own_ff, dest_bc_ff, pat_ok_ff;
  logic [3:0] pulse_cnt_ff;
  logic level_ff;
  logic magic_found;
  // Register decode.
  wire logic [15:0] a = bus.addr;
  wire logic sel_cfg = a == wfd_pkg::ADDR_RX_FILTER_CONFIG;
  wire logic sel_fstat = a == wfd_pkg::ADDR_RX_FILTER_STATUS;
  wire logic sel_istat = a == wfd_pkg::ADDR_INT_STATUS_TWO;
  wire logic sel_plen = a == wfd_pkg::ADDR_PATTERN_LEN;
  wire logic [15:0] st_off = a - wfd_pkg::ADDR_STATION_0;
  wire logic [15:0] pw_off = a - wfd_pkg::ADDR_PASSWORD_0;
  wire logic [15:0] pm_off = a - wfd_pkg::ADDR_PATTERN_BASE;
  wire logic sel_st = st_off < 16'h0003;
  wire logic sel_pw = pw_off < 16'h0003;
  wire logic sel_pm = pm_off < 16'(wfd_pkg::PATTERN_WORDS);
  wire logic [4:0] pm_idx = pm_off[4:0];
  wire logic wr_cfg = bus.wr && sel_cfg;
  wire logic wr_fstat = bus.wr && sel_fstat;
  wire logic wr_istat = bus.wr && sel_istat;
  // Configuration fields.
  wire logic magic_en = cfg_ff[wfd_pkg::CFG_MAGIC_EN];
  wire logic pat_en = cfg_ff[wfd_pkg::CFG_PATTERN_EN];
  wire logic pass_en = cfg_ff[wfd_pkg::CFG_PASS_EN];
  wire logic bcast_en = cfg_ff[wfd_pkg::CFG_BCAST_EN];
  wire logic level_mode = cfg_ff[wfd_pkg::CFG_LEVEL_MODE];
  wire logic [1:0] gpio_sel = cfg_ff[wfd_pkg::CFG_GPIO_SEL +: 2];
  // Frame tracking on the byte stream; speed plays no part in matching.
  wire logic byte_in = rx.vld;
  wire logic [2:0] dst_idx = count_ff[2:0];
  wire logic in_dest = count_ff < 16'(wfd_pkg::ADDR_BYTES);
  wire logic own_byte = rx.data == wfd_pkg::wfd_byte_of(station_ff, dst_idx);
  wire logic bc_byte = rx.data == wfd_pkg::wfd_byte_of(wfd_pkg::BROADCAST, dst_idx);
  wire logic [5:0] pb_idx = count_ff[5:0];
  wire logic [15:0] pword = pattern_mem[pb_idx[5:1]];
  wire logic [7:0] pbyte = pb_idx[0] ? pword[7:0] : pword[15:8];
  wire logic in_pat = count_ff < 16'(pat_len_ff);
  wire logic dest_ok = dest_own_ff || (bcast_en && dest_bc_ff);
  wire logic magic_hit = magic_en && magic_found && dest_ok;
  wire logic pat_hit = pat_en && pat_ok_ff && pat_len_ff != 7'h00
    && count_ff >= 16'(pat_len_ff);
  wire logic any_hit = rx.eof && (magic_hit || pat_hit);
  wire logic wake_evt = any_hit && !rx.crc_err;
  wire logic reject_evt = any_hit && rx.crc_err;
  wfd_magic_seq u_seq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .byte_vld(byte_in),
    .byte_data(rx.data),
    .frame_start(rx.sof),
    .station(station_ff),
    .password(password_ff),
    .pass_en(pass_en),
    .found(magic_found)
  );
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 16'h0000;
      dest_own_ff <= 1'b1;
      dest_bc_ff <= 1'b1;
      pat_ok_ff <= 1'b1;
    end else if (rx.sof) begin
      count_ff <= 16'h0000;
      dest_own_ff <= 1'b1;
      dest_bc_ff <= 1'b1;
      pat_ok_ff <= 1'b1;
    end else if (byte_in) begin
      count_ff <= (count_ff == 16'hFFFF) ? count_ff : count_ff + 16'h0001;
      dest_own_ff <= dest_own_ff && (!in_dest || own_byte);
      dest_bc_ff <= dest_bc_ff && (!in_dest || bc_byte);
      pat_ok_ff <= pat_ok_ff && (!in_pat || rx.data == pbyte);
    end
  end
  // Status updates: hardware sets win over software clears.
  always_comb begin
    nxt_istat = istat_ff;
    if (wr_istat) begin
      nxt_istat = istat_ff & ~bus.wdata[1:0];
    end
    nxt_istat[wfd_pkg::ST_WAKE] = nxt_istat[wfd_pkg::ST_WAKE] | wake_evt;
    nxt_istat[wfd_pkg::ST_REJECT] = nxt_istat[wfd_pkg::ST_REJECT] | reject_evt;
    nxt_fstat = fstat_ff;
    if (wr_fstat) begin
      nxt_fstat = fstat_ff & ~bus.wdata;
    end
    if (wake_evt) begin
      nxt_fstat[wfd_pkg::ST_WAKE] = 1'b1;
      nxt_fstat[wfd_pkg::ST_MAGIC] = nxt_fstat[wfd_pkg::ST_MAGIC] | magic_hit;
      nxt_fstat[wfd_pkg::ST_PATTERN] = nxt_fstat[wfd_pkg::ST_PATTERN] | pat_hit;
      nxt_fstat[wfd_pkg::ST_SPEED +: 2] = rx_speed;
    end
    if (reject_evt) begin
      nxt_fstat[wfd_pkg::ST_REJECT] = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_ff <= 2'h0;
      fstat_ff <= 16'h0000;
    end else begin
      istat_ff <= nxt_istat;
      fstat_ff <= nxt_fstat;
    end
  end
  // Software writable registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= wfd_pkg::CFG_RESET;
      imask_ff <= 2'h0;
      station_ff <= 48'h0000_0000_0000;
      password_ff <= 48'h0000_0000_0000;
      pat_len_ff <= 7'h00;
    end else if (bus.wr) begin
      if (sel_cfg) begin
        cfg_ff <= bus.wdata;
      end
      if (sel_istat) begin
        imask_ff <= bus.wdata[wfd_pkg::INT_MASK_POS +: 2];
      end
      if (sel_st) begin
        station_ff[6'(8'd32 - 8'(st_off[1:0]) * 8'd16) +: 16] <= bus.wdata;
      end
      if (sel_pw) begin
        password_ff[6'(8'd32 - 8'(pw_off[1:0]) * 8'd16) +: 16] <= bus.wdata;
      end
      if (sel_plen) begin
        pat_len_ff <= (bus.wdata > 16'(wfd_pkg::PATTERN_BYTES)) ?
          7'(wfd_pkg::PATTERN_BYTES) : bus.wdata[6:0];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (bus.wr && sel_pm) begin
      pattern_mem[pm_idx] <= bus.wdata;
    end
  end
  // Read path; unmapped addresses and pattern memory read as zero.
  always_comb begin
    nxt_rdata = 16'h0000;
    if (sel_cfg) begin
      nxt_rdata = cfg_ff;
    end else if (sel_fstat) begin
      nxt_rdata = fstat_ff;
    end else if (sel_istat) begin
      nxt_rdata = {6'h00, imask_ff, 6'h00, istat_ff};
    end else if (sel_st) begin
      nxt_rdata = station_ff[6'(8'd32 - 8'(st_off[1:0]) * 8'd16) +: 16];
    end else if (sel_pw) begin
      nxt_rdata = password_ff[6'(8'd32 - 8'(pw_off[1:0]) * 8'd16) +: 16];
    end else if (sel_plen) begin
      nxt_rdata = {9'h000, pat_len_ff};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= bus.rd ? nxt_rdata : 16'h0000;
    end
  end
  assign rdata = rdata_ff;
  // Wake indication on the selected GPIO: fixed pulse or level held until status clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_ff <= 4'h0;
      level_ff <= 1'b0;
      gpio_event <= 4'h0;
    end else begin
      if (wake_evt && !level_mode) begin
        pulse_cnt_ff <= 4'(wfd_pkg::PULSE_CYC);
      end else if (pulse_cnt_ff != 4'h0) begin
        pulse_cnt_ff <= pulse_cnt_ff - 4'h1;
      end
      level_ff <= level_mode && nxt_fstat[wfd_pkg::ST_WAKE];
      gpio_event <= 4'h0;
      gpio_event[gpio_sel] <= level_ff || (pulse_cnt_ff != 4'h0);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_istat & nxt_imask());
    end
  end
  function automatic logic [1:0] nxt_imask();
    nxt_imask = wr_istat ? bus.wdata[wfd_pkg::INT_MASK_POS +: 2] : imask_ff;
  endfunction
  // Checks.
  // Shadow of the first six frame bytes, so the destination check does not reuse the flags.
  logic [47:0] seen_dst_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_dst_ff <= 48'h0000_0000_0000;
    end else if (byte_in && in_dest) begin
      seen_dst_ff <= {seen_dst_ff[39:0], rx.data};
    end
  end
  // Length of the current run of a high wake pin in pulse mode.
  logic [3:0] gpio_run_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_run_ff <= 4'h0;
    end else if (gpio_event == 4'h0 || level_mode) begin
      gpio_run_ff <= 4'h0;
    end else if (gpio_run_ff != 4'hF) begin
      gpio_run_ff <= gpio_run_ff + 4'h1;
    end
  end
  crc_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx.eof && rx.crc_err) |=> !$rose(istat_ff[wfd_pkg::ST_WAKE]))
    else $error("Wake flag rose on a frame with a bad check sequence.");
  wake_at_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(fstat_ff[wfd_pkg::ST_WAKE]) |-> $past(rx.eof))
    else $error("Wake status rose away from a frame end.");
  dest_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && !pat_hit) |-> (seen_dst_ff == station_ff
    || (bcast_en && seen_dst_ff == wfd_pkg::BROADCAST)))
    else $error("Magic wake from a frame not addressed to this node.");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_evt |=> istat_ff[wfd_pkg::ST_WAKE] && fstat_ff[wfd_pkg::ST_WAKE])
    else $error("Wake event did not set both status flags.");
  irq_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((istat_ff & imask_ff) != 2'h0) && !wr_istat |=> irq)
    else $error("Unmasked wake status did not raise the interrupt.");
  pulse_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && !level_mode && !wr_cfg) |-> ##2 gpio_event[gpio_sel] [*8])
    else $error("Wake pulse shorter than its set width.");
  pulse_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && !level_mode && !wr_cfg) |-> ##10 gpio_event == 4'h0)
    else $error("Wake pulse did not end after its set width.");
  pulse_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gpio_run_ff <= 4'(wfd_pkg::PULSE_CYC))
    else $error("Wake pulse longer than its set width.");
  pulse_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pulse_cnt_ff <= 4'(wfd_pkg::PULSE_CYC))
    else $error("Pulse counter above its set width.");
  gpio_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (gpio_event & ~(4'h1 << $past(gpio_sel))) == 4'h0)
    else $error("Wake shown on a pin that is not selected.");
  level_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (level_mode && fstat_ff[wfd_pkg::ST_WAKE] && !wr_fstat && !wr_cfg) |-> ##2 gpio_event != 4'h0)
    else $error("Wake level dropped while the wake status was set.");
  pattern_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && !magic_hit) |-> pat_en && count_ff >= 16'(pat_len_ff))
    else $error("Pattern wake without pattern mode or full length.");
  plen_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pat_len_ff <= 7'(wfd_pkg::PATTERN_BYTES))
    else $error("Pattern length above the pattern size.");
  plen_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && sel_plen) |=> rdata == {9'h000, $past(pat_len_ff)})
    else $error("Pattern length read returned a wrong value.");
  pattern_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && pat_hit) |=> fstat_ff[wfd_pkg::ST_PATTERN])
    else $error("Pattern wake not recorded in the status.");
  magic_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_evt && magic_hit) |=> fstat_ff[wfd_pkg::ST_MAGIC])
    else $error("Magic wake not recorded in the status.");
  cfg_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && sel_cfg && !$past(wr_cfg)) |=> rdata == $past(cfg_ff))
    else $error("Configuration read returned a wrong value.");
  cfg_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_cfg |=> cfg_ff == $past(bus.wdata))
    else $error("Configuration write did not land.");
  fstat_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && sel_fstat) |=> rdata == $past(fstat_ff))
    else $error("Filter status read returned a wrong value.");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(bus.rd) |-> rdata == 16'h0000)
    else $error("Read data not zero outside a read answer.");
  fstat_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fstat_ff[wfd_pkg::ST_WAKE] && !wr_fstat) |=> fstat_ff[wfd_pkg::ST_WAKE])
    else $error("Filter wake status dropped without a clear.");
  istat_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (istat_ff[wfd_pkg::ST_WAKE] && !wr_istat) |=> istat_ff[wfd_pkg::ST_WAKE])
    else $error("Wake flag dropped without a clear.");
  wake_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_istat && bus.wdata[wfd_pkg::ST_WAKE] && !wake_evt) |=> !istat_ff[wfd_pkg::ST_WAKE])
    else $error("Wake flag not cleared by a written one.");
  istat_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && sel_istat) |=> rdata == {6'h00, $past(imask_ff), 6'h00, $past(istat_ff)})
    else $error("Interrupt status read returned a wrong value.");
  mask_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_istat |=> imask_ff == $past(bus.wdata[wfd_pkg::INT_MASK_POS +: 2]))
    else $error("Interrupt mask write did not land.");
  irq_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((istat_ff & imask_ff) == 2'h0 && !wake_evt && !reject_evt && !wr_istat) |=> !irq)
    else $error("Interrupt raised with no unmasked flag.");
  reject_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reject_evt |=> istat_ff[wfd_pkg::ST_REJECT] && fstat_ff[wfd_pkg::ST_REJECT])
    else $error("Rejected frame did not set both reject flags.");
  wake_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx.eof && !magic_en && !pat_en) |=> !$rose(istat_ff[wfd_pkg::ST_WAKE]))
    else $error("Wake flag rose with both match modes off.");
  frame_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx.sof |=> count_ff == 16'h0000)
    else $error("Frame start did not restart the byte count.");
  speed_log_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_evt |=> fstat_ff[wfd_pkg::ST_SPEED +: 2] == $past(rx_speed))
    else $error("Wake status did not record the line speed.");
  pass_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_evt && pass_en);
  magic_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_evt && magic_hit);
  pattern_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_evt && pat_hit);
  crc_reject_c: cover property (@(posedge sys_clk) disable iff (!rst_n) reject_evt);
  level_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_evt && level_mode);
endmodule
`default_nettype wire

// file: verification/wfd_rx_src.sv
// Receive datapath model: plays one frame at a time into the detector's byte stream.
// Assumes it is called just after a rising edge of sys_clk by the testbench.
`default_nettype none
module wfd_rx_src (
  input wire logic sys_clk,
  output var wfd_pkg::wfd_rx_t rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx = '0;
  // Sends start pulse, bytes each followed by gap idle cycles, then end pulse with check flag.
  task automatic send(input logic [7:0] f[$], input logic bad, input int gap);
    @(posedge sys_clk);
    rx.sof <= 1'b1;
    @(posedge sys_clk);
    rx.sof <= 1'b0;
    foreach (f[i]) begin
      rx.vld <= 1'b1;
      rx.data <= f[i];
      @(posedge sys_clk);
      if (gap > 0) begin
        rx.vld <= 1'b0;
        rx.data <= ~rx.data;
        repeat (gap) @(posedge sys_clk);
      end
    end
    rx.vld <= 1'b0;
    rx.data <= ~rx.data;
    rx.eof <= 1'b1;
    rx.crc_err <= bad;
    @(posedge sys_clk);
    rx.eof <= 1'b0;
    rx.crc_err <= ~bad;
  endtask
endmodule
`default_nettype wire

// file: verification/wfd_testbench.sv
// Self-checking bench of the wake frame detector: register port, frames, events.
// Assumes the receive model wfd_rx_src and the detector share one 25 MHz clock.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_CFG = wfd_pkg::ADDR_RX_FILTER_CONFIG;
  localparam logic [15:0] A_ST = wfd_pkg::ADDR_RX_FILTER_STATUS;
  localparam logic [15:0] A_INT = wfd_pkg::ADDR_INT_STATUS_TWO;
  localparam logic [47:0] STN = 48'h0A1B_2C3D_4E5F;
  localparam logic [47:0] PWD = 48'h5A6B_7C8D_9EAF;
  typedef struct packed {
    logic [47:0] dest;
    logic [3:0] nsync;
    logic [4:0] copies;
    logic [15:0] cfg;
    logic exp;
  } wfd_case_t;
  localparam wfd_case_t CASES [6] = '{
    '{48'hFFFF_FFFF_FFFF, 4'h6, 5'h10, 16'h0041, 1'b0},
    '{48'hFFFF_FFFF_FFFF, 4'h6, 5'h10, 16'h0049, 1'b1},
    '{48'h0A1B_2C3D_4E50, 4'h6, 5'h10, 16'h0049, 1'b0},
    '{STN, 4'h6, 5'h0F, 16'h0041, 1'b0},
    '{STN, 4'h5, 5'h10, 16'h0041, 1'b0},
    '{STN, 4'h6, 5'h10, 16'h0040, 1'b0}};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  wfd_pkg::wfd_rx_t rx;
  wfd_pkg::wfd_bus_t bus = '0;
  logic [1:0] rx_speed = 2'h1;
  logic [15:0] rdata;
  logic irq;
  logic [3:0] gpio_event;
  int failures = 0;
  int checks = 0;
  logic [7:0] q[$];
  always #20 sys_clk = ~sys_clk;
  wfd_rx_src src (.sys_clk(sys_clk), .rx(rx));
  wfd_detector dut (.sys_clk(sys_clk), .rst_n(rst_n), .rx(rx), .rx_speed(rx_speed),
    .bus(bus), .rdata(rdata), .irq(irq), .gpio_event(gpio_event));
  task automatic close_out();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic clr();
    wr(A_ST, 16'hFFFF);
    wr(A_INT, 16'h0103);
  endtask
  task automatic put48(input logic [47:0] v);
    for (int i = 5; i >= 0; i--) q.push_back(v[8*i +: 8]);
  endtask
  // Frame: destination, source, optional broken partial sequence, sync, copies, password.
  task automatic magic(input logic [47:0] d, input int pre, input int ns, input int n,
    input logic pw);
    q = {};
    put48(d);
    put48(48'h0011_2233_4455);
    if (pre > 0) begin
      repeat (6) q.push_back(8'hFF);
      repeat (pre) put48(STN);
    end
    repeat (ns) q.push_back(8'hFF);
    repeat (n) put48(STN);
    if (pw) put48(PWD);
    q.push_back(8'h00);
  endtask
  // Called at the end-of-frame edge; checks irq and a still quiet pin, then counts gpio highs.
  task automatic ev(input logic ei, input int n);
    int c;
    c = 0;
    #1;
    chk({15'h0, irq}, {15'h0, ei});
    chk({12'h0, gpio_event}, 16'h0);
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      if (gpio_event === 4'h4) c++;
    end
    chk(16'(c), 16'(n));
  endtask
  task automatic t_reset();
    rdc(A_CFG, 16'h0);
    rdc(A_ST, 16'h0);
    rdc(A_INT, 16'h0);
    rdc(16'h0200, 16'h0);
    wr(A_CFG, 16'h0041);
    rdc(A_CFG, 16'h0041);
    wr(16'h04A2, STN[47:32]);
    wr(16'h04A3, STN[31:16]);
    wr(16'h04A4, STN[15:0]);
    wr(A_INT, 16'h0100);
    rdc(A_INT, 16'h0100);
  endtask
  task automatic t_magic();
    magic(STN, 3, 6, 16, 1'b0);
    src.send(q, 1'b0, 0);
    ev(1'b1, 8);
    rdc(A_ST, 16'h0015);
    rdc(A_INT, 16'h0101);
    clr();
    rdc(A_INT, 16'h0100);
    chk({15'h0, irq}, 16'h0);
  endtask
  task automatic t_crc();
    magic(STN, 0, 6, 16, 1'b0);
    src.send(q, 1'b1, 1);
    ev(1'b0, 0);
    rdc(A_ST, 16'h0002);
    rdc(A_INT, 16'h0102);
    clr();
  endtask
  task automatic t_cases();
    foreach (CASES[i]) begin
      wr(A_CFG, CASES[i].cfg);
      magic(CASES[i].dest, 0, int'(CASES[i].nsync), int'(CASES[i].copies), 1'b0);
      src.send(q, 1'b0, 0);
      ev(CASES[i].exp, CASES[i].exp ? 8 : 0);
      rdc(A_ST, CASES[i].exp ? 16'h0015 : 16'h0000);
      clr();
    end
  endtask
  task automatic t_pass();
    wr(16'h04A5, PWD[47:32]);
    wr(16'h04A6, PWD[31:16]);
    wr(16'h04A7, PWD[15:0]);
    wr(A_CFG, 16'h0045);
    for (int p = 0; p < 2; p++) begin
      magic(STN, 0, 6, 16, p[0]);
      src.send(q, 1'b0, 0);
      ev(p[0], p * 8);
      clr();
    end
  endtask
  task automatic t_pattern();
    wr(A_CFG, 16'h0052);
    wr(wfd_pkg::ADDR_PATTERN_LEN, 16'h0004);
    wr(wfd_pkg::ADDR_PATTERN_BASE, STN[47:32]);
    wr(wfd_pkg::ADDR_PATTERN_BASE + 16'h1, STN[31:16]);
    magic(PWD, 0, 0, 0, 1'b0);
    src.send(q, 1'b0, 0);
    ev(1'b0, 0);
    magic(STN, 0, 0, 0, 1'b0);
    src.send(q, 1'b0, 0);
    ev(1'b1, 10);
    rdc(A_ST, 16'h0019);
    clr();
    repeat (3) @(posedge sys_clk);
    #1;
    chk({12'h0, gpio_event}, 16'h0);
  endtask
  task automatic t_speed();
    wr(A_CFG, 16'h0041);
    for (int s = 0; s < 3; s++) begin
      rx_speed <= 2'(s);
      magic(STN, 0, 6, 16, 1'b0);
      src.send(q, 1'b0, 2 - s);
      ev(1'b1, 8);
      rdc(A_ST, 16'h0005 | 16'(s << 4));
      clr();
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_magic();
    t_crc();
    t_cases();
    t_pass();
    t_pattern();
    t_speed();
    close_out();
  end
  initial begin
    #(40 * 30000);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
